// [tb.sv]
// Self-checking bench for the watchdog block with timed access.
`timescale 1ns/1ps
module tb;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic       cpu_reset, wdog_timeout_irq, bandgap_in_stop, evt_irq;
	logic [5:0] timer_speed_ctrl;
	logic [3:0] ext_irq_enable;
	int         fail_count = 0;
	int         n_checks = 0;
	int         per [4] = '{16, 32, 64, 128};
	int         c, m;
	// Short periods keep the run brief; every period expectation uses per[].
	wdta_top #(.PERIOD0_CYC(27'd16), .PERIOD1_CYC(27'd32), .PERIOD2_CYC(27'd64),
		.PERIOD3_CYC(27'd128)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cpu_reset(cpu_reset), .wdog_timeout_irq(wdog_timeout_irq), .evt_irq(evt_irq),
		.bandgap_in_stop(bandgap_in_stop), .timer_speed_ctrl(timer_speed_ctrl),
		.ext_irq_enable(ext_irq_enable));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// ----
	// Bus tasks
	// ----
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
	endtask
	task idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata, e);
		@(posedge sys_clk);
	endtask
	task look(input logic [12:0] e);
		idle(0);
		@(negedge sys_clk);
		chk({timer_speed_ctrl, ext_irq_enable, evt_irq, wdog_timeout_irq, bandgap_in_stop}, e);
		@(posedge sys_clk);
	endtask
	task unlock(input logic [7:0] a, input logic [7:0] d);
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
		wr(a, d);
	endtask
	// Both waits are bounded, so a dead counter shows as a bad count.
	task run_out(input int p);
		idle(0);
		c = 0;
		m = 0;
		while (wdog_timeout_irq !== 1'b1 && c < 2000) begin
			@(negedge sys_clk);
			c++;
		end
		chk(c >= p && c <= p + 2, 1);
		while (cpu_reset !== 1'b1 && m < 2000) begin
			@(negedge sys_clk);
			m++;
		end
		@(posedge sys_clk);
	endtask
	task tend(input int k);
		$display("test %0d ended, mismatches %0d", k, fail_count);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(8'hD8, 8'h40);
		rd(8'h8E, 8'h00);
		rd(8'hE8, 8'h00);
		rd(8'hC7, 8'h00);
		rd(8'h10, 8'h00);
		tend(1);
		wr(8'h8E, 8'hFF);
		wr(8'hE8, 8'hFF);
		look({6'h3F, 4'hF, 3'b000});
		rd(8'h8E, 8'hFF);
		rd(8'hE8, 8'h1F);
		tend(2);
		wr(8'h8E, 8'h00);
		wr(8'hE8, 8'h00);
		wr(8'h91, 8'h01);
		wr(8'hD8, 8'h0A);
		look(13'h0000);
		rd(8'hD8, 8'h40);
		rd(8'hF1, 8'h04);
		unlock(8'h91, 8'h01);
		wr(8'h91, 8'h00);
		look(13'h0001);
		unlock(8'h8E, 8'h00);
		wr(8'hC7, 8'h56);
		wr(8'h91, 8'h00);
		look(13'h0001);
		wr(8'hC7, 8'hAA);
		wr(8'hE8, 8'h00);
		wr(8'hC7, 8'h55);
		wr(8'h91, 8'h00);
		look(13'h0001);
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
		idle(1);
		wr(8'h91, 8'h00);
		look(13'h0000);
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h55);
		idle(2);
		wr(8'h91, 8'h01);
		look(13'h0000);
		wr(8'hF2, 8'h07);
		tend(3);
		for (int s = 0; s < 4; s++) begin
			wr(8'h8E, {s[1:0], 6'h00});
			wr(8'hE8, 8'h10);
			unlock(8'hD8, 8'h02);
			run_out(per[s]);
			chk(m, 512);
			rd(8'hD8, 8'h0E);
			rd(8'hF1, 8'h03);
			wr(8'hF3, 8'h07);
			look(13'h0006);
			unlock(8'hD8, 8'h00);
			wr(8'hF2, 8'h07);
			look(13'h0000);
			rd(8'hD8, 8'h00);
		end
		tend(4);
		wr(8'hF3, 8'h00);
		wr(8'h8E, 8'h00);
		wr(8'hE8, 8'h00);
		unlock(8'hD8, 8'h02);
		repeat (4) begin
			idle(10);
			unlock(8'hD8, 8'h03);
		end
		idle(0);
		c = 0;
		while (cpu_reset !== 1'b1 && c < 2000) begin
			@(negedge sys_clk);
			c++;
		end
		chk(c >= per[0] + 513 && c <= per[0] + 515, 1);
		chk(wdog_timeout_irq, 1'b0);
		@(posedge sys_clk);
		rd(8'hD8, 8'h0E);
		wr(8'hE8, 8'h10);
		look(13'h0002);
		unlock(8'hD8, 8'h00);
		wr(8'hE8, 8'h00);
		look(13'h0000);
		tend(5);
		complete_run();
	end
endmodule

// [wdta_asserts.sv]
// Port checker for the watchdog block with timed access.
`timescale 1ns/1ps
module wdta_asserts (
	input wire       sys_clk,
	input wire       rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       cpu_reset,
	input wire       wdog_timeout_irq,
	input wire       bandgap_in_stop,
	input wire [5:0] timer_speed_ctrl,
	input wire [3:0] ext_irq_enable,
	input wire       evt_irq
);
	// ----
	// Bus shadows
	// ----
	wire       k55_w = reg_wr && reg_addr == 8'hC7 && reg_wdata == 8'h55;
	wire       ck_w = reg_wr && reg_addr == 8'h8E;
	wire       ie_w = reg_wr && reg_addr == 8'hE8;
	wire       key_rd = reg_rd && reg_addr == 8'hC7;
	reg        ie_r;
	reg  [9:0] since_r;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// A rise caused by an enable write is no expiry, so it starts no count.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ie_r <= 1'b0;
			since_r <= 10'h000;
		end else begin
			if (ie_w)
				ie_r <= reg_wdata[4];
			if (cpu_reset || !wdog_timeout_irq)
				since_r <= 10'h000;
			else if ($rose(wdog_timeout_irq) && !$past(ie_w))
				since_r <= 10'h001;
			else if (since_r != 10'h000 && since_r != 10'h3FF)
				since_r <= since_r + 10'h001;
		end
	end
	// ----
	// Properties
	// ----
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_key_reads_zero: assert property ($past(key_rd) |-> reg_rdata == 8'h00)
		else $error("key register read back nonzero");
	a_bite_single: assert property (cpu_reset |=> !cpu_reset)
		else $error("cpu reset longer than one cycle");
	a_bite_delay: assert property (cpu_reset && since_r != 10'h000 |-> since_r == 10'h200)
		else $error("cpu reset not 512 clocks after warning");
	a_irq_gated: assert property (wdog_timeout_irq |-> ie_r)
		else $error("watchdog request while disabled");
	a_irq_sticky: assert property ($fell(wdog_timeout_irq) |-> $past(reg_wr))
		else $error("watchdog request dropped without a write");
	a_bg_guarded: assert property ($changed(bandgap_in_stop) |-> $past(reg_wr) &&
		($past(k55_w, 2) || $past(k55_w, 3)))
		else $error("band-gap bit changed without unlock");
	a_speed_write: assert property ($past(ck_w) |->
		{2'b00, timer_speed_ctrl} == ($past(reg_wdata) & 8'h3F))
		else $error("timer speed bits not written");
	a_ie_write: assert property ($past(ie_w) |->
		{4'h0, ext_irq_enable} == ($past(reg_wdata) & 8'h0F))
		else $error("interrupt enable bits not written");
	c_bite: cover property (cpu_reset);
	c_warn: cover property ($rose(wdog_timeout_irq));
	c_unlock: cover property ($rose(bandgap_in_stop));
endmodule
bind wdta_top wdta_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_reset(cpu_reset), .wdog_timeout_irq(wdog_timeout_irq), .evt_irq(evt_irq),
	.bandgap_in_stop(bandgap_in_stop), .timer_speed_ctrl(timer_speed_ctrl),
	.ext_irq_enable(ext_irq_enable));

// [wdta_counter.v]
// Watchdog interval counter with expiry warning and reset bite.
`timescale 1ns/1ps
module wdta_counter #(
	parameter [26:0] LEN0 = 27'h0020000,
	parameter [26:0] LEN1 = 27'h0100000,
	parameter [26:0] LEN2 = 27'h0800000,
	parameter [26:0] LEN3 = 27'h4000000
) (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       run,
	input  wire       restart,
	input  wire [1:0] sel,
	output reg        expire,
	output reg        bite
);
`include "wdta_defs.vh"

	reg  [26:0] cnt_r;
	wire        hit_exp;
	wire        hit_bite;

	function [26:0] period_len;
		input [1:0] s;
		begin
			case (s)
			2'h0:    period_len = LEN0;
			2'h1:    period_len = LEN1;
			2'h2:    period_len = LEN2;
			default: period_len = LEN3;
			endcase
		end
	endfunction

	assign hit_exp  = (cnt_r == period_len(sel) - `WDTA_CNT_ONE); // RL2
	assign hit_bite = (cnt_r == period_len(sel) + `WDTA_GRACE_CYC - `WDTA_CNT_ONE); // RL4

	// The count advances on every crystal clock, not a machine-cycle rate.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= `WDTA_CNT_ZERO;
			expire <= 1'b0;
			bite   <= 1'b0;
		end else begin
			if (!run || restart || hit_bite)
				cnt_r <= `WDTA_CNT_ZERO; // RL8
			else
				cnt_r <= cnt_r + `WDTA_CNT_ONE; // RL3
			expire <= run && !restart && hit_exp; // RL5
			bite   <= run && !restart && hit_bite; // RL1
		end
	end
endmodule

// [wdta_defs.vh]
// Register map, field positions and timing constants of the watchdog block.
`ifndef WDTA_DEFS_VH
`define WDTA_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WDTA_ADDR_SPEED   8'h8E
`define WDTA_ADDR_EXIF    8'h91
`define WDTA_ADDR_KEY     8'hC7
`define WDTA_ADDR_WDCTL   8'hD8
`define WDTA_ADDR_XIE     8'hE8
`define WDTA_ADDR_EVSTAT  8'hF1
`define WDTA_ADDR_EVCLR   8'hF2
`define WDTA_ADDR_EVEN    8'hF3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDTA_CK_SEL_HI    7
`define WDTA_CK_SEL_LO    6
`define WDTA_EXIF_BANDGAP 0
`define WDTA_WD_POR       6
`define WDTA_WD_IRQF      3
`define WDTA_WD_RSTF      2
`define WDTA_WD_EN        1
`define WDTA_WD_RESTART   0
`define WDTA_XIE_WDI      4
`define WDTA_XIE_W        5
`define WDTA_EV_EXPIRE    0
`define WDTA_EV_BITE      1
`define WDTA_EV_REFUSED   2
`define WDTA_EV_W         3

// ----------------------------------------------------------------
// Reset values, keys and timing
// ----------------------------------------------------------------
`define WDTA_SPEED_RST    8'h00
`define WDTA_XIE_RST      5'h00
`define WDTA_EV_RST       3'h0
`define WDTA_BYTE_ZERO    8'h00
`define WDTA_KEY_FIRST    8'hAA
`define WDTA_KEY_SECOND   8'h55
`define WDTA_WIN_CYC      2'h2
`define WDTA_WIN_LAST     2'h1
`define WDTA_GRACE_CYC    27'h0000200
`define WDTA_CNT_ZERO     27'h0000000
`define WDTA_CNT_ONE      27'h0000001

`endif

// [wdta_gate.v]
// Timed-access unlock sequencer that opens a short window for guarded writes.
`timescale 1ns/1ps
module wdta_gate (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire       key_wr,
	input  wire [7:0] key_data,
	input  wire       other_wr,
	input  wire       guarded_done,
	output wire       win_open
);
`include "wdta_defs.vh"

	localparam [2:0] S_IDLE  = 3'h1;
	localparam [2:0] S_ARMED = 3'h2;
	localparam [2:0] S_OPEN  = 3'h4;

	reg [2:0] state_r;
	reg [1:0] win_r;

	assign win_open = (state_r == S_OPEN);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_IDLE;
			win_r   <= 2'h0;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (key_wr && key_data == `WDTA_KEY_FIRST)
					state_r <= S_ARMED;
			end
			S_ARMED: begin
				if (key_wr && key_data == `WDTA_KEY_SECOND) begin
					state_r <= S_OPEN; // RL12
					win_r   <= `WDTA_WIN_CYC;
				end else if (key_wr && key_data == `WDTA_KEY_FIRST)
					state_r <= S_ARMED;
				else if (key_wr || other_wr)
					state_r <= S_IDLE; // RL16
			end
			S_OPEN: begin
				if (key_wr && key_data == `WDTA_KEY_FIRST)
					state_r <= S_ARMED;
				else if (key_wr || guarded_done || win_r == `WDTA_WIN_LAST)
					state_r <= S_IDLE; // RL16
				else
					win_r <= win_r - `WDTA_WIN_LAST;
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule

// [wdta_top.v]
// Watchdog with timed-access protection, register file and event interrupt.
//
// Contract
// RL1: An enabled watchdog resets the CPU unless restarted before the interval ends.
// RL2: The two-bit period select picks 2^17, 2^20, 2^23 or 2^26 clocks.
// RL3: The counter advances on every crystal clock, not on a divided rate.
// RL4: After expiry exactly 512 more clocks pass, then the CPU reset is given.
// RL5: The interrupt flag is set at expiry, 512 clocks ahead of the reset.
// RL6: A watchdog reset sets a reset-source flag for software to inspect.
// RL7: Setting the enable bit starts the watchdog, only through the unlock.
// RL8: Setting the restart bit restarts a full interval, only through the unlock.
// RL9: Software should restart the watchdog before changing the period select.
// RL10: The interrupt request is raised only while the interrupt enable bit is set.
// RL11: The interrupt request can wake the processor from idle as a time base.
// RL12: Writing AAh then 55h to the key register opens a two-cycle guarded window.
// RL13: A guarded write outside an open window is ignored.
// RL14: Band-gap select, power-on flag, enable, restart and interrupt flag are guarded.
// RL15: Software waking on the watchdog interrupt should restart it in its handler.
// RL16: The unlock returns to idle on window end, guarded write or a wrong second key; a second AAh re-arms it instead.
// RL17: The interrupt and reset flags stay set until software writes them to zero.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module wdta_top #(
	parameter [26:0] PERIOD0_CYC = 27'h0020000,
	parameter [26:0] PERIOD1_CYC = 27'h0100000,
	parameter [26:0] PERIOD2_CYC = 27'h0800000,
	parameter [26:0] PERIOD3_CYC = 27'h4000000
) (
	input  wire       sys_clk,
	input  wire       rst_n,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output wire [7:0] reg_rdata,
	output wire       cpu_reset,
	output wire       wdog_timeout_irq,
	output wire       bandgap_in_stop,
	output wire [5:0] timer_speed_ctrl,
	output wire [3:0] ext_irq_enable,
	output wire       evt_irq
);
`include "wdta_defs.vh"

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
	reg  [7:0] speed_ctl_r;
	reg        bandgap_r;
	reg        por_r;
	reg        irq_flag_r;
	reg        rst_flag_r;
	reg        wd_en_r;
	reg  [4:0] xie_r;
	reg  [2:0] ev_stat_r;
	reg  [2:0] ev_stat_nxt;
	reg  [2:0] ev_en_r;
	reg  [7:0] rdata_r;
	reg  [7:0] rdata_nxt;
	reg        cpu_reset_r;
	reg        restart_r;

	wire       win_open;
	wire       expire;
	wire       bite;

// ----------------------------------------------------------------
// Write decode
// ----------------------------------------------------------------
	wire wr_speed  = reg_wr && reg_addr == `WDTA_ADDR_SPEED;
	wire wr_exif   = reg_wr && reg_addr == `WDTA_ADDR_EXIF;
	wire wr_key    = reg_wr && reg_addr == `WDTA_ADDR_KEY;
	wire wr_wdctl  = reg_wr && reg_addr == `WDTA_ADDR_WDCTL;
	wire wr_xie    = reg_wr && reg_addr == `WDTA_ADDR_XIE;
	wire wr_evclr  = reg_wr && reg_addr == `WDTA_ADDR_EVCLR;
	wire wr_even   = reg_wr && reg_addr == `WDTA_ADDR_EVEN;

	// Only the register holders of guarded bits consume the window.
	wire wr_guard_reg = wr_wdctl || wr_exif; // RL14
	wire guarded_ok   = wr_guard_reg && win_open;
	wire guarded_bad  = wr_guard_reg && !win_open;

	// A write is counted as refused only when it tried to change a guarded bit.
	wire wdctl_change = reg_wdata[`WDTA_WD_POR]     != por_r      ||
	                    reg_wdata[`WDTA_WD_IRQF]    != irq_flag_r ||
	                    reg_wdata[`WDTA_WD_EN]      != wd_en_r    ||
	                    reg_wdata[`WDTA_WD_RESTART];
	wire exif_change  = reg_wdata[`WDTA_EXIF_BANDGAP] != bandgap_r;
	wire refused      = guarded_bad &&
	                    ((wr_wdctl && wdctl_change) || (wr_exif && exif_change)); // RL13

	wire other_wr = reg_wr && !wr_key;

// ----------------------------------------------------------------
// Timed-access unlock
// ----------------------------------------------------------------
	wdta_gate u_gate (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.key_wr       (wr_key),
		.key_data     (reg_wdata),
		.other_wr     (other_wr),
		.guarded_done (guarded_ok),
		.win_open     (win_open)
	);

// ----------------------------------------------------------------
// Interval counter
// ----------------------------------------------------------------
	wdta_counter #(
		.LEN0 (PERIOD0_CYC),
		.LEN1 (PERIOD1_CYC),
		.LEN2 (PERIOD2_CYC),
		.LEN3 (PERIOD3_CYC)
	) u_counter (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.run     (wd_en_r),
		.restart (restart_r),
		.sel     (speed_ctl_r[`WDTA_CK_SEL_HI:`WDTA_CK_SEL_LO]),
		.expire  (expire),
		.bite    (bite)
	);

// ----------------------------------------------------------------
// Plain control registers
// ----------------------------------------------------------------
	// Changing the period select mid-count moves the target under a running
	// count, so software is expected to restart first; nothing stops it here.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			speed_ctl_r <= `WDTA_SPEED_RST;
			xie_r       <= `WDTA_XIE_RST;
			ev_en_r     <= `WDTA_EV_RST;
		end else begin
			if (wr_speed)
				speed_ctl_r <= reg_wdata;
			if (wr_xie)
				xie_r <= reg_wdata[`WDTA_XIE_W-1:0];
			if (wr_even)
				ev_en_r <= reg_wdata[`WDTA_EV_W-1:0];
		end
	end

// ----------------------------------------------------------------
// Guarded bits and watchdog flags
// ----------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bandgap_r <= 1'b0;
			por_r     <= 1'b1;
			wd_en_r   <= 1'b0;
			restart_r <= 1'b0;
		end else begin
			restart_r <= 1'b0;
			if (guarded_ok && wr_exif)
				bandgap_r <= reg_wdata[`WDTA_EXIF_BANDGAP]; // RL14
			if (guarded_ok && wr_wdctl) begin
				por_r     <= reg_wdata[`WDTA_WD_POR]; // RL14
				wd_en_r   <= reg_wdata[`WDTA_WD_EN]; // RL7
				restart_r <= reg_wdata[`WDTA_WD_RESTART]; // RL8
			end
		end
	end

	// Hardware sets win over a clearing write in the same cycle.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_r <= 1'b0;
			rst_flag_r <= 1'b0;
		end else begin
			if (expire)
				irq_flag_r <= 1'b1; // RL5
			else if (guarded_ok && wr_wdctl)
				irq_flag_r <= reg_wdata[`WDTA_WD_IRQF]; // RL17
			if (bite)
				rst_flag_r <= 1'b1; // RL6
			else if (wr_wdctl && !reg_wdata[`WDTA_WD_RSTF])
				rst_flag_r <= 1'b0; // RL17
		end
	end

// ----------------------------------------------------------------
// CPU reset and watchdog interrupt request
// ----------------------------------------------------------------
	// The reset is a single registered pulse; this block sits outside the
	// CPU reset domain so the reset-source flag survives it.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			cpu_reset_r <= 1'b0;
		else
			cpu_reset_r <= bite; // RL1
	end

	assign cpu_reset = cpu_reset_r;

	// A level request, so it also serves as the idle wake-up source.
	assign wdog_timeout_irq = irq_flag_r && xie_r[`WDTA_XIE_WDI]; // RL10 RL11

// ----------------------------------------------------------------
// Event status, clear and enable
// ----------------------------------------------------------------
	always @* begin
		ev_stat_nxt = ev_stat_r;
		if (wr_evclr)
			ev_stat_nxt = ev_stat_nxt & ~reg_wdata[`WDTA_EV_W-1:0];
		if (expire)
			ev_stat_nxt[`WDTA_EV_EXPIRE] = 1'b1;
		if (bite)
			ev_stat_nxt[`WDTA_EV_BITE] = 1'b1;
		if (refused)
			ev_stat_nxt[`WDTA_EV_REFUSED] = 1'b1;
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ev_stat_r <= `WDTA_EV_RST;
		else
			ev_stat_r <= ev_stat_nxt;
	end

	assign evt_irq = |(ev_stat_r & ev_en_r);

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
	always @* begin
		rdata_nxt = `WDTA_BYTE_ZERO;
		case (reg_addr)
		`WDTA_ADDR_SPEED:  rdata_nxt = speed_ctl_r;
		`WDTA_ADDR_EXIF:   rdata_nxt[`WDTA_EXIF_BANDGAP] = bandgap_r;
		`WDTA_ADDR_WDCTL: begin
			rdata_nxt[`WDTA_WD_POR]  = por_r;
			rdata_nxt[`WDTA_WD_IRQF] = irq_flag_r;
			rdata_nxt[`WDTA_WD_RSTF] = rst_flag_r;
			rdata_nxt[`WDTA_WD_EN]   = wd_en_r;
		end
		`WDTA_ADDR_XIE:    rdata_nxt[`WDTA_XIE_W-1:0] = xie_r;
		`WDTA_ADDR_EVSTAT: rdata_nxt[`WDTA_EV_W-1:0] = ev_stat_r;
		`WDTA_ADDR_EVEN:   rdata_nxt[`WDTA_EV_W-1:0] = ev_en_r;
		default:           rdata_nxt = `WDTA_BYTE_ZERO;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_r <= `WDTA_BYTE_ZERO;
		else if (reg_rd)
			rdata_r <= rdata_nxt;
		else
			rdata_r <= `WDTA_BYTE_ZERO;
	end

	assign reg_rdata = rdata_r;

// ----------------------------------------------------------------
// Outputs to neighbouring units
// ----------------------------------------------------------------
	assign bandgap_in_stop  = bandgap_r;
	assign timer_speed_ctrl = speed_ctl_r[`WDTA_CK_SEL_LO-1:0];
	assign ext_irq_enable   = xie_r[`WDTA_XIE_WDI-1:0];

endmodule
